// file: hdl/fault_flag_if.sv
// set, clear and state of one sticky flag register
`timescale 1ns/1ps
`default_nettype none
interface fault_flag_if;
    logic [7:0] setBits;
    logic [7:0] clrBits;
    logic [7:0] flags;
    modport owner (input setBits, input clrBits, output flags);
    modport user (output setBits, output clrBits, input flags);
endinterface
`default_nettype wire

// file: hdl/fault_flags_pkg.sv
// shared constants for the thermal and overcurrent fault flag bank
package fault_flags_pkg;
    localparam int REG_WIDTH = 8;
    localparam int HOT_COUNT = 5;
    localparam int OC_COUNT = 3;
    localparam logic [7:0] THERMAL_HOT_FLAGS_OFFSET = 8'hB5;
    localparam logic [7:0] OVERCURRENT_FLAGS_OFFSET = 8'hB6;
    localparam logic [7:0] THERMAL_HOT_FLAGS_RESET = 8'h00;
    localparam logic [7:0] OVERCURRENT_FLAGS_RESET = 8'h00;
    localparam logic [7:0] THERMAL_HOT_VALID_MASK = 8'h1F;
    localparam logic [7:0] OVERCURRENT_VALID_MASK = 8'h07;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
    localparam int HOT_DIE_BIT = 4;
    localparam int HOT_TERMINATION_BIT = 3;
    localparam int HOT_TOP_RIGHT_BIT = 2;
    localparam int HOT_TOP_LEFT_BIT = 1;
    localparam int HOT_BOTTOM_RIGHT_BIT = 0;
    localparam int OC_SIXTH_BIT = 2;
    localparam int OC_SECOND_BIT = 1;
    localparam int OC_FIRST_BIT = 0;
endpackage

// file: hdl/sticky_flag_reg.sv
// one write-one-to-clear sticky flag register
`timescale 1ns/1ps
`default_nettype none
module sticky_flag_reg
    import fault_flags_pkg::*;
#(
    parameter logic [7:0] VALID_MASK = 8'hFF,
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // flag carrier
    fault_flag_if.owner flagIf
);
    logic [7:0] flags_ff;
    logic [7:0] nxt_flags;

    // RULE_13 set beats clear
    always_comb begin
        nxt_flags = ((flags_ff & ~flagIf.clrBits) | flagIf.setBits) & VALID_MASK;
    end

    // RULE_12 reset to zero
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_ff <= RESET_VALUE;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    assign flagIf.flags = flags_ff;

    property p_sticky_hold;
        @(posedge sys_clk) disable iff (!rst_b)
        (flags_ff != 8'h00) |=> ((($past(flags_ff) & ~$past(flagIf.clrBits)) & ~flags_ff) == 8'h00);
    endproperty
    a_sticky_hold: assert property (p_sticky_hold) else $error("flag dropped without clear"); // RULE_13

    property p_clear_one;
        @(posedge sys_clk) disable iff (!rst_b)
        ((flagIf.clrBits & ~flagIf.setBits & VALID_MASK) != 8'h00)
            |=> ((flags_ff & $past(flagIf.clrBits & ~flagIf.setBits)) == 8'h00);
    endproperty
    a_clear_one: assert property (p_clear_one) else $error("write one did not clear flag"); // RULE_10

    property p_reserved_zero;
        @(posedge sys_clk) disable iff (!rst_b)
        (flags_ff & ~VALID_MASK) == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved flag bit set"); // RULE_11
endmodule
`default_nettype wire

// file: hdl/thermal_overcurrent_fault_flags.sv
// sticky thermal hot and overcurrent fault flags with register access
// Contract
// RULE_01 - rest-of-die hot sets thermal hot bit 4.
// RULE_02 - termination regulator hot sets thermal hot bit 3.
// RULE_03 - top-right corner hot sets thermal hot bit 2.
// RULE_04 - top-left corner hot sets thermal hot bit 1.
// RULE_05 - bottom-right corner hot sets thermal hot bit 0.
// RULE_06 - five separate sensor inputs, one per thermal hot flag.
// RULE_07 - sixth buck controller low-side overcurrent sets overcurrent bit 2.
// RULE_08 - second buck controller low-side overcurrent sets overcurrent bit 1.
// RULE_09 - first buck controller low-side overcurrent sets overcurrent bit 0.
// RULE_10 - flags read 1 when asserted; writing 1 clears them.
// RULE_11 - upper unused bits of both registers read zero, read-only.
// RULE_12 - both registers reset to all zero.
// RULE_13 - flags stay set until cleared; writing 0 changes nothing.
// RULE_14 - critical temperature flags live elsewhere, same clear behaviour.
`timescale 1ns/1ps
`default_nettype none
module thermal_overcurrent_fault_flags
    import fault_flags_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // temperature sensors above hot threshold
    input wire logic dieHot,
    input wire logic terminationRegulatorHot,
    input wire logic topRightHot,
    input wire logic topLeftHot,
    input wire logic bottomRightHot,
    // low-side overcurrent detectors
    input wire logic sixthBuckControllerOc,
    input wire logic secondBuckControllerOc,
    input wire logic firstBuckControllerOc,
    // register access port
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    output logic regRdValid,
    // flag state
    output logic [7:0] thermalHotFlags,
    output logic [7:0] overcurrentFlags
);
    fault_flag_if hotIf ();
    fault_flag_if ocIf ();

    logic [7:0] rdData_ff;
    logic rdValid_ff;
    logic [7:0] nxt_rdData;

    // clear bits for a write hitting one register
    function automatic logic [7:0] clearBits(
        input logic wrEn,
        input logic [7:0] addr,
        input logic [7:0] offset,
        input logic [7:0] data,
        input logic [7:0] mask
    );
        clearBits = (wrEn && (addr == offset)) ? (data & mask) : 8'h00;
    endfunction

    // RULE_06 one sensor per flag
    always_comb begin
        hotIf.setBits = 8'h00;
        // RULE_01 rest of die
        hotIf.setBits[HOT_DIE_BIT] = dieHot;
        // RULE_02 termination regulator
        hotIf.setBits[HOT_TERMINATION_BIT] = terminationRegulatorHot;
        // RULE_03 top-right corner
        hotIf.setBits[HOT_TOP_RIGHT_BIT] = topRightHot;
        // RULE_04 top-left corner
        hotIf.setBits[HOT_TOP_LEFT_BIT] = topLeftHot;
        // RULE_05 bottom-right corner
        hotIf.setBits[HOT_BOTTOM_RIGHT_BIT] = bottomRightHot;
    end

    always_comb begin
        ocIf.setBits = 8'h00;
        // RULE_07 sixth controller
        ocIf.setBits[OC_SIXTH_BIT] = sixthBuckControllerOc;
        // RULE_08 second controller
        ocIf.setBits[OC_SECOND_BIT] = secondBuckControllerOc;
        // RULE_09 first controller
        ocIf.setBits[OC_FIRST_BIT] = firstBuckControllerOc;
    end

    // RULE_10 write one clears
    assign hotIf.clrBits = clearBits(regWrEn, regAddr, THERMAL_HOT_FLAGS_OFFSET, regWrData,
                                     THERMAL_HOT_VALID_MASK);
    assign ocIf.clrBits = clearBits(regWrEn, regAddr, OVERCURRENT_FLAGS_OFFSET, regWrData,
                                    OVERCURRENT_VALID_MASK);

    // RULE_14 reusable write-one-clear register
    sticky_flag_reg #(
        .VALID_MASK(THERMAL_HOT_VALID_MASK),
        .RESET_VALUE(THERMAL_HOT_FLAGS_RESET)
    ) hotReg (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .flagIf(hotIf.owner)
    );

    sticky_flag_reg #(
        .VALID_MASK(OVERCURRENT_VALID_MASK),
        .RESET_VALUE(OVERCURRENT_FLAGS_RESET)
    ) ocReg (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .flagIf(ocIf.owner)
    );

    // RULE_11 reserved bits read zero
    always_comb begin
        unique case (regAddr)
            THERMAL_HOT_FLAGS_OFFSET: nxt_rdData = hotIf.flags & THERMAL_HOT_VALID_MASK;
            OVERCURRENT_FLAGS_OFFSET: nxt_rdData = ocIf.flags & OVERCURRENT_VALID_MASK;
            default: nxt_rdData = UNMAPPED_READ_VALUE;
        endcase
    end

    // read data capture
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdData_ff <= 8'h00;
        end else if (regRdEn) begin
            rdData_ff <= nxt_rdData;
        end
    end

    // read valid pulse
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdValid_ff <= 1'b0;
        end else begin
            rdValid_ff <= regRdEn;
        end
    end

    assign regRdData = rdData_ff;
    assign regRdValid = rdValid_ff;
    assign thermalHotFlags = hotIf.flags;
    assign overcurrentFlags = ocIf.flags;

    property p_die_hot;
        @(posedge sys_clk) disable iff (!rst_b)
        dieHot |=> thermalHotFlags[4];
    endproperty
    a_die_hot: assert property (p_die_hot) else $error("die hot flag not set"); // RULE_01

    property p_term_hot;
        @(posedge sys_clk) disable iff (!rst_b)
        terminationRegulatorHot |=> thermalHotFlags[3];
    endproperty
    a_term_hot: assert property (p_term_hot) else $error("termination hot flag not set"); // RULE_02

    property p_top_right_hot;
        @(posedge sys_clk) disable iff (!rst_b)
        topRightHot |=> thermalHotFlags[2];
    endproperty
    a_top_right_hot: assert property (p_top_right_hot) else $error("top-right hot flag not set"); // RULE_03

    property p_top_left_hot;
        @(posedge sys_clk) disable iff (!rst_b)
        topLeftHot |=> thermalHotFlags[1];
    endproperty
    a_top_left_hot: assert property (p_top_left_hot) else $error("top-left hot flag not set"); // RULE_04

    property p_bottom_right_hot;
        @(posedge sys_clk) disable iff (!rst_b)
        bottomRightHot |=> thermalHotFlags[0];
    endproperty
    a_bottom_right_hot: assert property (p_bottom_right_hot) else $error("bottom-right hot flag not set"); // RULE_05

    property p_hot_source;
        @(posedge sys_clk) disable iff (!rst_b)
        $rose(thermalHotFlags[4]) |-> $past(dieHot);
    endproperty
    a_hot_source: assert property (p_hot_source) else $error("die hot flag set without sensor"); // RULE_06

    property p_oc_sixth;
        @(posedge sys_clk) disable iff (!rst_b)
        sixthBuckControllerOc |=> overcurrentFlags[2];
    endproperty
    a_oc_sixth: assert property (p_oc_sixth) else $error("sixth overcurrent flag not set"); // RULE_07

    property p_oc_second;
        @(posedge sys_clk) disable iff (!rst_b)
        secondBuckControllerOc |=> overcurrentFlags[1];
    endproperty
    a_oc_second: assert property (p_oc_second) else $error("second overcurrent flag not set"); // RULE_08

    property p_oc_first;
        @(posedge sys_clk) disable iff (!rst_b)
        firstBuckControllerOc |=> overcurrentFlags[0];
    endproperty
    a_oc_first: assert property (p_oc_first) else $error("first overcurrent flag not set"); // RULE_09

    property p_read_hot;
        @(posedge sys_clk) disable iff (!rst_b)
        (regRdEn && regAddr == THERMAL_HOT_FLAGS_OFFSET) |=> (regRdValid && regRdData == $past(thermalHotFlags));
    endproperty
    a_read_hot: assert property (p_read_hot) else $error("thermal hot read mismatch"); // RULE_10

    property p_read_reserved;
        @(posedge sys_clk) disable iff (!rst_b)
        (regRdEn && regAddr == OVERCURRENT_FLAGS_OFFSET) |=> (regRdData[7:3] == 5'h00);
    endproperty
    a_read_reserved: assert property (p_read_reserved) else $error("overcurrent reserved bits not zero"); // RULE_11

    property p_reset_zero;
        @(posedge sys_clk)
        $rose(rst_b) |-> (thermalHotFlags == 8'h00 && overcurrentFlags == 8'h00);
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("flags not zero after reset"); // RULE_12

    property p_write_zero;
        @(posedge sys_clk) disable iff (!rst_b)
        (regWrEn && regAddr == OVERCURRENT_FLAGS_OFFSET && regWrData == 8'h00)
            |=> ((overcurrentFlags & $past(overcurrentFlags)) == $past(overcurrentFlags));
    endproperty
    a_write_zero: assert property (p_write_zero) else $error("write of zero changed a flag"); // RULE_13
endmodule
`default_nettype wire

// file: sim/reg_host_model.sv
// host model driving the flag register port
`timescale 1ns/1ps
`default_nettype none
module reg_host_model (
    // clock
    input wire logic sys_clk,
    // register port
    output logic [7:0] regAddr,
    output logic regWrEn,
    output logic [7:0] regWrData,
    output logic regRdEn
);
    initial begin
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        regRdEn = 1'b0;
    end
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        @(negedge sys_clk);
        regAddr = addr;
        regWrData = data;
        regWrEn = wr;
        regRdEn = !wr;
        @(negedge sys_clk);
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        // released lines show the inverted last value
        regAddr = ~addr;
        regWrData = ~data;
    endtask
endmodule
`default_nettype wire

// file: sim/thermal_overcurrent_fault_flags_tb_top.sv
// self-checking bench for the fault flag register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin nTests++; if ((got) !== (exp)) begin errTotal++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module thermal_overcurrent_fault_flags_tb_top
    import fault_flags_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [4:0] hotIn = 5'h00;
    logic [2:0] ocIn = 3'h0;
    logic [7:0] regAddr, regWrData, regRdData, thermalHotFlags, overcurrentFlags, rdExp;
    logic regWrEn, regRdEn, regRdValid;
    logic [7:0] expHot = 8'h00;
    logic [7:0] expOc = 8'h00;
    logic [7:0] rdQ[$];
    int errTotal = 0;
    int nTests = 0;
    always #50 sys_clk = ~sys_clk;
    reg_host_model i_host (.sys_clk(sys_clk), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn));
    thermal_overcurrent_fault_flags i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .dieHot(hotIn[4]),
        .terminationRegulatorHot(hotIn[3]), .topRightHot(hotIn[2]), .topLeftHot(hotIn[1]),
        .bottomRightHot(hotIn[0]), .sixthBuckControllerOc(ocIn[2]), .secondBuckControllerOc(ocIn[1]),
        .firstBuckControllerOc(ocIn[0]), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
        .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
        .thermalHotFlags(thermalHotFlags), .overcurrentFlags(overcurrentFlags));
    task automatic closeOut();
        $display("counts: compares=%0d mismatches=%0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        rdQ.push_back(exp);
        i_host.access(1'b0, addr, 8'h00);
    endtask
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        i_host.access(1'b1, addr, data);
        if (addr == THERMAL_HOT_FLAGS_OFFSET) expHot = (expHot & ~data) | {3'b000, hotIn};
        if (addr == OVERCURRENT_FLAGS_OFFSET) expOc = (expOc & ~data) | {5'b00000, ocIn};
    endtask
    task automatic fault(input logic [7:0] hv, input logic [7:0] ov);
        @(negedge sys_clk);
        hotIn = hv[4:0];
        ocIn = ov[2:0];
        @(negedge sys_clk);
        hotIn = 5'h00;
        ocIn = 3'h0;
        expHot |= {3'b000, hv[4:0]};
        expOc |= {5'b00000, ov[2:0]};
    endtask
    task automatic chkFlags();
        `CHK(thermalHotFlags, expHot)
        `CHK(overcurrentFlags, expOc)
    endtask
    // read results against the oldest note
    always @(negedge sys_clk) begin
        if (regRdValid === 1'b1) begin
            rdExp = (rdQ.size() > 0) ? rdQ.pop_front() : 8'hXX;
            `CHK(regRdData, rdExp)
        end
    end
    initial begin
        repeat (4000) @(posedge sys_clk);
        errTotal++;
        $display("watchdog expired");
        closeOut();
    end
    initial begin
        logic [31:0] v;
        logic [7:0] sel;
        void'($urandom(45469));
        repeat (5) @(negedge sys_clk);
        rst_b = 1'b1;
        chkFlags();
        rd(THERMAL_HOT_FLAGS_OFFSET, THERMAL_HOT_FLAGS_RESET);
        rd(OVERCURRENT_FLAGS_OFFSET, OVERCURRENT_FLAGS_RESET);
        rd(8'hB7, UNMAPPED_READ_VALUE);
        $display("test reset values done");
        for (int i = 0; i < 8; i++) begin
            sel = 8'h01 << i;
            fault(i < 5 ? sel : 8'h00, i < 5 ? 8'h00 : sel >> 5);
            `CHK(thermalHotFlags[4:0], sel[4:0])
            `CHK(overcurrentFlags[2:0], sel[7:5])
            wr(THERMAL_HOT_FLAGS_OFFSET, 8'h00);
            wr(OVERCURRENT_FLAGS_OFFSET, 8'h00);
            rd(THERMAL_HOT_FLAGS_OFFSET, expHot);
            rd(OVERCURRENT_FLAGS_OFFSET, expOc);
            wr(THERMAL_HOT_FLAGS_OFFSET, 8'hFF);
            wr(OVERCURRENT_FLAGS_OFFSET, 8'hFF);
            chkFlags();
        end
        $display("test flag mapping done");
        @(negedge sys_clk);
        hotIn = 5'h1F;
        ocIn = 3'h7;
        wr(THERMAL_HOT_FLAGS_OFFSET, 8'hFF);
        wr(OVERCURRENT_FLAGS_OFFSET, 8'hFF);
        hotIn = 5'h00;
        ocIn = 3'h0;
        chkFlags();
        rst_b = 1'b0;
        expHot = 8'h00;
        expOc = 8'h00;
        @(negedge sys_clk);
        chkFlags();
        `CHK(regRdValid, 1'b0)
        rst_b = 1'b1;
        $display("test set wins and reset done");
        for (int k = 0; k < 24; k++) begin
            v = $urandom;
            repeat (v[28:27]) @(negedge sys_clk);
            fault(v[7:0], v[15:8]);
            wr(8'hB4 + {6'h00, v[25:24]}, v[23:16]);
            rd(THERMAL_HOT_FLAGS_OFFSET, expHot);
            rd(OVERCURRENT_FLAGS_OFFSET, expOc);
        end
        $display("test random traffic done");
        @(posedge sys_clk);
        `CHK(rdQ.size(), 0)
        closeOut();
    end
endmodule
`default_nettype wire
